// ### pkg/fwd_arb_pkg.sv
// Constants, field layout and carrier types for the output forwarding arbiter.
// Assumes a single clock domain and an APB register bus with 32-bit data.
package fwd_arb_pkg;
   localparam int NUM_PORTS = 4;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTL_ONE = 8'h20;
   localparam logic [7:0] IDX_CTL_TWO = 8'h21;
   localparam logic [7:0] IDX_STATE = 8'h22;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_CTL_ONE = ADDR_W'({IDX_CTL_ONE, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_CTL_TWO = ADDR_W'({IDX_CTL_TWO, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_STATE = ADDR_W'({IDX_STATE, 2'b00});
   // Reset values
   localparam logic [7:0] RST_CTL_ONE = 8'hF0;
   localparam logic [7:0] RST_CTL_TWO = 8'h03;
   // Field positions
   localparam int OFF_LSB = 4;
   localparam int SWR_BIT = 6;
   localparam int MODE_LSB = 2;
   localparam int ROT_BIT = 0;
   localparam int CTL_TWO_RW_MSB = 6;
   localparam int LOST_BIT = 2;
   localparam int OK_BIT = 0;
   // Lockstep mode encodings
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_BASIC = 2'b01,
      MODE_INTERLEAVE = 2'b10,
      MODE_CONCAT = 2'b11
   } lockstep_mode_type;
   // Head-of-buffer packet kinds
   typedef enum logic [1:0] {
      KIND_LINE = 2'b00,
      KIND_FRAME_START = 2'b01,
      KIND_FRAME_END = 2'b10,
      KIND_OTHER_SHORT = 2'b11
   } pkt_kind_type;
   typedef struct packed {
      logic valid;
      pkt_kind_type kind;
   } rx_head_type;
   typedef struct packed {
      logic valid;
      logic [NUM_PORTS-1:0] ports;
      pkt_kind_type kind;
      logic concat;
   } fwd_cmd_type;
endpackage

// ### rtl/fwd_arbiter.sv
// Forwarding arbiter merging up to four receive-port line buffers onto one output.
// Assumes buffers present a head packet on rx_head and drop it on a pop pulse, and the
// transmitter pulses tx_done once a forwarded command has been sent; both on clk_sys.
// Heads need only update in the cycle after a pop; the engine waits for that.
//
// Contract
// - Lockstep waits for lines on all enabled ports
// - Send-when-ready forwards each line once present
// - Send-when-ready ignored for concatenation, short packets and lockstep mode off
// - Mode field bits 3:2 select lockstep variant
// - Rotating mode serves ready sources in turn
// - Lost flag set only after a synced frame
// - Reading lost flag returns it then clears
// - Status ok bit shows currently synchronized delivery
// - Status ok bit zero when lockstep disabled
// - Per-port forward-off bits gate enabled sources
`timescale 1ns/1ps
module fwd_arbiter
   import fwd_arb_pkg::*;
#(
   parameter int PORTS = NUM_PORTS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire rx_head_type [PORTS-1:0] rx_head,
   output logic [PORTS-1:0] rx_pop,
   output fwd_cmd_type fwd_cmd,
   input wire logic tx_done
);

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } eng_state_type;

   // First set bit of mask at or after start, wrapping
   function automatic logic [PORTS-1:0] pick_from(input logic [PORTS-1:0] mask,
                                                  input logic [1:0] start);
      logic [PORTS-1:0] res;
      logic found;
      int k;
      res = '0;
      found = 1'b0;
      for (int i = 0; i < PORTS; i++) begin
         k = (int'(start) + i) % PORTS;
         if (!found && mask[k]) begin
            res[k] = 1'b1;
            found = 1'b1;
         end
      end
      return res;
   endfunction

   function automatic logic [1:0] index_of(input logic [PORTS-1:0] onehot);
      logic [1:0] idx;
      idx = '0;
      for (int i = 0; i < PORTS; i++) begin
         if (onehot[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction

   logic [7:0] ctl_one_q, ctl_one_d;
   logic [7:0] ctl_two_q, ctl_two_d;
   logic lost_q, lost_d;
   logic ok_q, ok_d;
   logic frame_sent_q, frame_sent_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   eng_state_type state_q, state_d;
   fwd_cmd_type cmd_q, cmd_d;
   logic [PORTS-1:0] pend_q, pend_d;
   logic [PORTS-1:0] pop_q, pop_d;
   logic [1:0] last_q, last_d;

   logic [PORTS-1:0] enabled;
   logic [PORTS-1:0] head_valid;
   logic [PORTS-1:0] head_line;
   logic all_ready;
   logic kinds_match;
   logic mismatch;
   logic send_when_ready;
   logic rotating;
   lockstep_mode_type mode;
   logic access;
   logic rd_state;
   logic heads_settling;

   assign enabled = ~ctl_one_q[OFF_LSB +: PORTS];
   assign send_when_ready = ctl_two_q[SWR_BIT];
   assign rotating = ctl_two_q[ROT_BIT];
   assign mode = lockstep_mode_type'(ctl_two_q[MODE_LSB +: 2]);
   assign access = psel && penable && !pready_q;
   assign rd_state = access && !pwrite && (paddr == ADDR_STATE);
   // A popped head is still shown during the pop cycle; deciding on it would
   // forward the same packet twice and could fake a sync loss, so the engine
   // sits that cycle out at a small cost in throughput
   assign heads_settling = (pop_q != '0);

   generate
      for (genvar g = 0; g < PORTS; g++) begin : g_head
         assign head_valid[g] = rx_head[g].valid && enabled[g];
         assign head_line[g] = head_valid[g] && (rx_head[g].kind == KIND_LINE);
      end
   endgenerate

   // Heads are aligned when every enabled port holds a packet of one kind
   always_comb begin
      pkt_kind_type ref_kind;
      logic first;
      ref_kind = KIND_LINE;
      first = 1'b1;
      kinds_match = 1'b1;
      for (int i = 0; i < PORTS; i++) begin
         if (head_valid[i]) begin
            if (first) begin
               ref_kind = rx_head[i].kind;
               first = 1'b0;
            end else if (rx_head[i].kind != ref_kind) begin
               kinds_match = 1'b0;
            end
         end
      end
   end

   // No enabled port means nothing to align; lockstep then stays idle
   assign all_ready = (enabled != '0) && ((head_valid & enabled) == enabled);
   assign mismatch = all_ready && !kinds_match;

   // APB slave: one extra cycle per access, no further wait states;
   // pready, pslverr and read data are registered so they stand together
   always_comb begin
      ctl_one_d = ctl_one_q;
      ctl_two_d = ctl_two_q;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      pready_d = access;
      if (access) begin
         prdata_d = '0;
         unique case (paddr)
            ADDR_CTL_ONE: begin
               if (pwrite) begin
                  ctl_one_d = pwdata[7:0];
               end else begin
                  prdata_d[7:0] = ctl_one_q;
               end
            end
            ADDR_CTL_TWO: begin
               if (pwrite) begin
                  ctl_two_d = {1'b0, pwdata[CTL_TWO_RW_MSB:0]};
               end else begin
                  prdata_d[7:0] = ctl_two_q;
               end
            end
            ADDR_STATE: begin
               // Writes are ignored; lost is cleared by the read itself
               prdata_d[LOST_BIT] = lost_q;
               prdata_d[OK_BIT] = ok_q && (mode != MODE_OFF);
            end
            default: begin
               pslverr_d = 1'b1;
            end
         endcase
      end
   end

   // Forwarding engine
   always_comb begin
      logic [PORTS-1:0] sel;
      state_d = state_q;
      cmd_d = cmd_q;
      pend_d = pend_q;
      pop_d = '0;
      last_d = last_q;
      ok_d = ok_q;
      frame_sent_d = frame_sent_q;
      lost_d = lost_q;
      sel = '0;
      // A read clear in the same cycle as a new loss gives way to the set
      if (rd_state) begin
         lost_d = 1'b0;
      end
      // Leaving lockstep forgets frame history; a later loss needs a new frame
      if (mode == MODE_OFF) begin
         ok_d = 1'b0;
         frame_sent_d = 1'b0;
      end
      unique case (state_q)
         ST_IDLE: begin
            cmd_d.valid = 1'b0;
            cmd_d.concat = 1'b0;
            if (heads_settling) begin
               // Stale heads this cycle; sync bookkeeping waits as well
               sel = '0;
            end else if (pend_q != '0) begin
               // Drain aligned lines one port at a time
               sel = pick_from(pend_q, last_q + 2'd1);
               pend_d = pend_q & ~sel;
               cmd_d.kind = KIND_LINE;
            end else if (rotating) begin
               // No alignment attempted in rotating mode
               sel = pick_from(head_valid, last_q + 2'd1);
               cmd_d.kind = rx_head[index_of(sel)].kind;
            end else if (mode != MODE_OFF) begin
               if (mismatch) begin
                  // Alignment broken: pass short packets singly to regain lock
                  ok_d = 1'b0;
                  frame_sent_d = 1'b0;
                  lost_d = frame_sent_q || lost_d;
                  sel = pick_from(head_valid & ~head_line, 2'd0);
                  cmd_d.kind = rx_head[index_of(sel)].kind;
               end else if (all_ready) begin
                  ok_d = 1'b1;
                  cmd_d.kind = rx_head[index_of(pick_from(enabled, 2'd0))].kind;
                  if (cmd_d.kind != KIND_LINE) begin
                     // Short packets always wait for every port
                     sel = enabled;
                     if (cmd_d.kind == KIND_FRAME_END && ok_q) begin
                        frame_sent_d = 1'b1;
                     end
                  end else if (mode == MODE_CONCAT) begin
                     sel = enabled;
                     cmd_d.concat = 1'b1;
                  end else begin
                     sel = pick_from(enabled, last_q + 2'd1);
                     pend_d = enabled & ~sel;
                  end
               end else if (send_when_ready && mode != MODE_CONCAT) begin
                  // Lines only; short packets keep waiting
                  sel = pick_from(head_line, last_q + 2'd1);
                  cmd_d.kind = KIND_LINE;
               end
            end
            if (sel != '0) begin
               cmd_d.valid = 1'b1;
               cmd_d.ports = sel;
               last_d = index_of(pick_from(sel, 2'd0));
               state_d = ST_SEND;
            end
         end
         ST_SEND: begin
            if (tx_done) begin
               pop_d = cmd_q.ports;
               cmd_d.valid = 1'b0;
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctl_one_q <= RST_CTL_ONE;
         ctl_two_q <= RST_CTL_TWO;
         lost_q <= 1'b0;
         ok_q <= 1'b0;
         frame_sent_q <= 1'b0;
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         state_q <= ST_IDLE;
         cmd_q <= '0;
         pend_q <= '0;
         pop_q <= '0;
         last_q <= '0;
      end else begin
         ctl_one_q <= ctl_one_d;
         ctl_two_q <= ctl_two_d;
         lost_q <= lost_d;
         ok_q <= ok_d;
         frame_sent_q <= frame_sent_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         state_q <= state_d;
         cmd_q <= cmd_d;
         pend_q <= pend_d;
         pop_q <= pop_d;
         last_q <= last_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign rx_pop = pop_q;
   assign fwd_cmd = cmd_q;

endmodule

// ### verification/fwd_arbiter_chk.sv
// Port checker for the forwarding arbiter.
// Assumes the map and reset values of fwd_arb_pkg; shadows control writes.
`timescale 1ns/1ps
module fwd_arbiter_chk
   import fwd_arb_pkg::*;
#(
   parameter int PORTS = NUM_PORTS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire rx_head_type [PORTS-1:0] rx_head,
   input wire logic [PORTS-1:0] rx_pop,
   input wire fwd_cmd_type fwd_cmd,
   input wire logic tx_done
);
   logic [7:0] two_q, two_d;
   logic [PORTS-1:0] off_q, off_d, hv;
   logic fe_q, fe_d, wr, rd_st, all_rdy;
   logic [1:0] mode;
   always_comb begin
      wr = psel && penable && pready && pwrite;
      rd_st = psel && penable && pready && !pwrite && paddr == ADDR_STATE;
      for (int i = 0; i < PORTS; i++) hv[i] = rx_head[i].valid;
      all_rdy = &(hv | off_q);
      mode = two_q[MODE_LSB +: 2];
      two_d = (wr && paddr == ADDR_CTL_TWO) ? pwdata[7:0] : two_q;
      off_d = (wr && paddr == ADDR_CTL_ONE) ? pwdata[OFF_LSB +: PORTS] : off_q;
      fe_d = fe_q || (fwd_cmd.valid && tx_done && fwd_cmd.kind == KIND_FRAME_END);
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         two_q <= RST_CTL_TWO;
         off_q <= '1;
         fe_q <= 1'b0;
      end else begin
         two_q <= two_d;
         off_q <= off_d;
         fe_q <= fe_d;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_apb_ans;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_apb_ans: assert property (p_apb_ans) else $error("pready late or long");
   property p_cmd_hold;
      fwd_cmd.valid && !tx_done |=> fwd_cmd.valid && $stable(fwd_cmd);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped");
   property p_pop;
      fwd_cmd.valid && tx_done |=> rx_pop == $past(fwd_cmd.ports) && !fwd_cmd.valid;
   endproperty
   a_pop: assert property (p_pop) else $error("bad pop after send");
   property p_off;
      fwd_cmd.valid |-> (fwd_cmd.ports & off_q) == '0;
   endproperty
   a_off: assert property (p_off) else $error("disabled port forwarded");
   property p_ok_off;
      rd_st && mode == MODE_OFF |-> !prdata[OK_BIT];
   endproperty
   a_ok_off: assert property (p_ok_off) else $error("ok set while off");
   property p_lost;
      rd_st |-> !prdata[LOST_BIT] || fe_q;
   endproperty
   a_lost: assert property (p_lost) else $error("lost before a frame");
   property p_concat;
      $rose(fwd_cmd.valid) && !two_q[ROT_BIT] && mode == MODE_CONCAT
         && fwd_cmd.kind == KIND_LINE
         |-> fwd_cmd.concat && fwd_cmd.ports == ~off_q && $past(all_rdy);
   endproperty
   a_concat: assert property (p_concat) else $error("bad joined line");
   property p_one;
      fwd_cmd.valid && (two_q[ROT_BIT] || (mode inside {MODE_BASIC, MODE_INTERLEAVE}
         && fwd_cmd.kind == KIND_LINE))
         |-> $onehot(fwd_cmd.ports) && !fwd_cmd.concat;
   endproperty
   a_one: assert property (p_one) else $error("not one port");
endmodule
bind fwd_arbiter fwd_arbiter_chk #(.PORTS(PORTS)) chk (.clk_sys, .rst_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_head, .rx_pop, .fwd_cmd,
   .tx_done);

// ### verification/fwd_arbiter_tb.sv
// Self-checking bench for the forwarding arbiter.
// Assumes the package map; line buffers are modelled by per-port counters.
`timescale 1ns/1ps
module fwd_arbiter_tb;
   import fwd_arb_pkg::*;
   logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, tx_done;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0] ld, rx_pop;
   rx_head_type [3:0] rx_head;
   fwd_cmd_type fwd_cmd;
   int cnt[4] = '{0, 0, 0, 0};
   pkt_kind_type kd[4] = '{KIND_LINE, KIND_LINE, KIND_LINE, KIND_LINE};
   int bad_count = 0;
   int checked = 0;
   logic [32:0] rd_q[$];
   logic [4:0] cmd_q[$];
   fwd_arbiter #(.PORTS(NUM_PORTS)) dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_head, .rx_pop, .fwd_cmd, .tx_done);
   fwd_tx_model tx (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(fwd_cmd.valid),
      .tx_done(tx_done));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Head changes the cycle after its pop
   always @(posedge clk_sys) begin
      for (int p = 0; p < 4; p++) cnt[p] <= cnt[p] + ld[p] - rx_pop[p];
   end
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         rx_head[p].valid = cnt[p] != 0;
         rx_head[p].kind = cnt[p] != 0 ? kd[p] : KIND_OTHER_SHORT;
      end
   end
   task automatic chk_rd(input logic [32:0] e, input logic [32:0] s);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected read exp %h got %h", e, s);
      end
   endtask
   task automatic chk_cmd(input logic [4:0] e, input logic [4:0] s);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected fwd_cmd exp %h got %h", e, s);
      end
   endtask
   always @(posedge clk_sys) begin
      if (fwd_cmd.valid && tx_done) chk_cmd(cmd_q.pop_front(), {fwd_cmd.ports, fwd_cmd.concat});
      if (psel && penable && pready && !pwrite) chk_rd(rd_q.pop_front(), {pslverr, prdata});
   end
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys iff pready);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic load(input logic [3:0] m);
      ld <= m;
      @(posedge clk_sys);
      ld <= 4'h0;
      @(posedge clk_sys);
   endtask
   task automatic idle_gap;
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      chk_cmd(5'h00, {4'h0, fwd_cmd.valid});
      @(posedge clk_sys);
   endtask
   task automatic drain;
      while (cmd_q.size() != 0) @(posedge clk_sys);
   endtask
   task automatic finish_test;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      finish_test;
   end
   initial begin
      void'($urandom(21269));
      {rst_n, psel, penable, pwrite, paddr, pwdata, ld} = '0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(ADDR_CTL_ONE, {25'h0, RST_CTL_ONE});
      rd(ADDR_CTL_TWO, {25'h0, RST_CTL_TWO});
      rd(ADDR_STATE, 33'h0);
      rd(12'h08C, {1'b1, 32'h0});
      r = $urandom;
      apb(1'b1, ADDR_CTL_ONE, {24'h0, 4'h8, r[3:0]});
      rd(ADDR_CTL_ONE, {25'h0, 4'h8, r[3:0]});
      cmd_q = '{5'h08, 5'h02, 5'h08, 5'h02};
      load(4'h5);
      load(4'h5);
      drain;
      for (int m = 1; m < 3; m++) begin
         apb(1'b1, ADDR_CTL_TWO, 32'(m << 2));
         rd(ADDR_CTL_TWO, 33'(m << 2));
         load(4'h1);
         idle_gap;
         cmd_q = '{5'h04, 5'h08, 5'h02};
         load(4'h6);
         drain;
         rd(ADDR_STATE, 33'h1);
      end
      apb(1'b1, ADDR_CTL_TWO, 32'h48);
      cmd_q = '{5'h08};
      load(4'h4);
      drain;
      apb(1'b1, ADDR_CTL_TWO, 32'h4C);
      load(4'h1);
      idle_gap;
      cmd_q = '{5'h0F};
      load(4'h6);
      drain;
      // Frame end while in sync, then mixed kinds to break sync, then realign
      apb(1'b1, ADDR_CTL_TWO, 32'h4);
      kd <= '{KIND_FRAME_END, KIND_FRAME_END, KIND_FRAME_END, KIND_LINE};
      cmd_q = '{5'h0E};
      load(4'h7);
      drain;
      kd <= '{KIND_FRAME_START, KIND_LINE, KIND_LINE, KIND_LINE};
      cmd_q = '{5'h02};
      load(4'h7);
      drain;
      kd[0] <= KIND_LINE;
      cmd_q = '{5'h04, 5'h08, 5'h02};
      load(4'h1);
      drain;
      rd(ADDR_STATE, 33'h5);
      rd(ADDR_STATE, 33'h1);
      apb(1'b1, ADDR_CTL_TWO, 32'h0);
      apb(1'b1, ADDR_STATE, 32'hFF);
      rd(ADDR_STATE, 33'h0);
      rd(ADDR_STATE, 33'h0);
      finish_test;
   end
endmodule

// ### verification/fwd_tx_model.sv
// Transmitter stand-in: acknowledges forwarded commands after 0..3 cycles.
// Assumes the command valid level holds until tx_done is seen.
`timescale 1ns/1ps
module fwd_tx_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cmd_valid,
   output logic tx_done
);
   int wait_q;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_done <= 1'b0;
         wait_q <= 0;
      end else if (tx_done) begin
         tx_done <= 1'b0;
      end else if (cmd_valid) begin
         // Random wait mixes prompt and slow acknowledgement
         if (wait_q == 0) begin
            tx_done <= 1'b1;
            wait_q <= $urandom % 4;
         end else begin
            wait_q <= wait_q - 1;
         end
      end
   end
endmodule
